//--- rtl/prxreg_pkg.sv
// Package for the proximity register bank and threshold event logic.
// Assumes one 40 MHz clock and I2C pins sampled synchronously to it.
`default_nettype none
package prxreg_pkg;
   // ==========================================================
   // Bus addressing
   localparam logic [6:0] PRX_TARGET_ADDR = 7'h60;
   // ==========================================================
   // Command codes
   localparam logic [7:0] PRX_CMD_ENABLE_INIT = 8'h00;
   localparam logic [7:0] PRX_CMD_PERIOD_INT = 8'h03;
   localparam logic [7:0] PRX_CMD_FORCE_EMIT = 8'h04;
   localparam logic [7:0] PRX_CMD_LOW_THRESH = 8'h05;
   localparam logic [7:0] PRX_CMD_HIGH_THRESH = 8'h06;
   localparam logic [7:0] PRX_CMD_CROSSTALK = 8'h07;
   localparam logic [7:0] PRX_CMD_AUTOCAL = 8'h08;
   localparam logic [7:0] PRX_CMD_RESULT = 8'hf8;
   localparam logic [7:0] PRX_CMD_FLAGS = 8'hf9;
   localparam logic [7:0] PRX_CMD_IDENT = 8'hfa;
   localparam logic [7:0] PRX_CMD_AC_RESULT = 8'hfb;
   // ==========================================================
   // Reset values
   localparam logic [7:0] PRX_RST_CONF_LOW = 8'h01;
   localparam logic [7:0] PRX_RST_ZERO = 8'h00;
   // Arbitrary neutral identity value
   localparam logic [15:0] PRX_IDENT_VALUE = 16'h5a3c;
   // ==========================================================
   // Field positions in period_interrupt_cfg
   localparam int PRX_PERS_HI = 5;
   localparam int PRX_PERS_LO = 4;
   localparam int PRX_MODE_HI = 3;
   localparam int PRX_MODE_LO = 2;
   localparam int PRX_FAST_BIT = 1;
   localparam int PRX_STOP_BIT = 0;
   // Event flag bit positions
   localparam int PRX_FLAG_AWAY = 0;
   localparam int PRX_FLAG_CLOSE = 1;
   // Interrupt mode codes
   localparam logic [1:0] PRX_MODE_OFF = 2'h0;
   localparam logic [1:0] PRX_MODE_LEVEL = 2'h1;
   localparam logic [1:0] PRX_MODE_FIRST_HIGH = 2'h2;
   localparam logic [1:0] PRX_MODE_ON = 2'h3;
   // Result width and persistence counter limit
   localparam int PRX_RESULT_W = 12;
   localparam logic [2:0] PRX_PERS_MAX = 3'h4;
   // ==========================================================
   // Bus engine states
   typedef enum logic [5:0] {
      PRX_ST_IDLE = 6'h01,
      PRX_ST_RX = 6'h02,
      PRX_ST_ACK = 6'h04,
      PRX_ST_TX = 6'h08,
      PRX_ST_TXACK = 6'h10,
      PRX_ST_WAIT = 6'h20
   } prx_state_e;
endpackage
`default_nettype wire

//--- rtl/prxreg_top.sv
// Register bank, I2C target and threshold event logic of the sensor.
// Assumes SCL and SDA are already synchronous to clk_in; the sample
// strobe and result come from the measurement core outside.
`default_nettype none
module prxreg_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // I2C pins (oe low means drive low)
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   // Measurement core
   input wire logic sample_valid_in,
   input wire logic [prxreg_pkg::PRX_RESULT_W-1:0] raw_result_in,
   input wire logic [15:0] autocal_result_in,
   output logic measure_run_out,
   output logic [7:0] force_mode_out,
   output logic [7:0] emitter_current_out,
   output logic [7:0] autocal_cfg_out,
   output logic [7:0] low_power_cfg_out,
   // Interrupt pin (open drain, active low)
   output logic int_n_out,
   output logic int_oe_n_out
);
   import prxreg_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      prx_state_e st;
      logic scl_d;
      logic sda_d;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic [1:0] bytecnt;
      logic rd;
      logic sda_low;
      logic [7:0] cmd;
      logic [7:0] wlow;
      logic [15:0] txword;
      logic [13:0][7:0] regs;
      logic [11:0] result;
      logic [7:0] flags;
      logic [2:0] pcnt_hi;
      logic [2:0] pcnt_lo;
      logic close;
      logic irq;
      logic armed;
   } prx_state_s;

   prx_state_s s_r;
   prx_state_s s_nxt;

   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [15:0] rd_word;
   logic [11:0] comp;
   logic [11:0] low_th;
   logic [11:0] high_th;
   logic [15:0] cancel;
   logic [2:0] pers;
   logic [1:0] mode;

   assign scl_rise = scl_in & ~s_r.scl_d;
   assign scl_fall = ~scl_in & s_r.scl_d;
   assign start_c = scl_in & s_r.scl_d & s_r.sda_d & ~sda_in;
   assign stop_c = scl_in & s_r.scl_d & ~s_r.sda_d & sda_in;
   assign low_th = {s_r.regs[7][3:0], s_r.regs[6]};
   assign high_th = {s_r.regs[9][3:0], s_r.regs[8]};
   assign cancel = {s_r.regs[11], s_r.regs[10]};
   assign pers = {1'b0, s_r.regs[2][PRX_PERS_HI:PRX_PERS_LO]} + 3'h1;
   assign mode = s_r.regs[2][PRX_MODE_HI:PRX_MODE_LO];

   // Crosstalk cancellation saturates at zero rather than wrap
   always_comb begin
      if ({4'h0, raw_result_in} > cancel) begin
         comp = 12'({4'h0, raw_result_in} - cancel);
      end else begin
         comp = 12'h000;
      end
   end

   // Read mux, byte index: low byte of code = even entry
   always_comb begin
      case (s_r.cmd)
         PRX_CMD_ENABLE_INIT: rd_word = {s_r.regs[1], s_r.regs[0]};
         PRX_CMD_PERIOD_INT: rd_word = {s_r.regs[3], s_r.regs[2]};
         PRX_CMD_FORCE_EMIT: rd_word = {s_r.regs[5], s_r.regs[4]};
         PRX_CMD_LOW_THRESH: rd_word = {s_r.regs[7], s_r.regs[6]};
         PRX_CMD_HIGH_THRESH: rd_word = {s_r.regs[9], s_r.regs[8]};
         PRX_CMD_CROSSTALK: rd_word = cancel;
         PRX_CMD_AUTOCAL: rd_word = {s_r.regs[13], s_r.regs[12]};
         PRX_CMD_RESULT: rd_word = {4'h0, s_r.result};
         PRX_CMD_FLAGS: rd_word = {s_r.flags, PRX_RST_ZERO};
         PRX_CMD_IDENT: rd_word = PRX_IDENT_VALUE;
         PRX_CMD_AC_RESULT: rd_word = autocal_result_in;
         default: rd_word = 16'h0000;
      endcase
   end

   // Next state: bus engine and threshold logic
   always_comb begin
      logic hi_now;
      logic lo_now;
      logic [2:0] need;
      hi_now = 1'b0;
      lo_now = 1'b0;
      need = 3'h1;
      s_nxt = s_r;
      s_nxt.scl_d = scl_in;
      s_nxt.sda_d = sda_in;

      // ========================= bus engine =====================
      if (start_c) begin
         s_nxt.st = PRX_ST_RX;
         s_nxt.bitcnt = 4'h0;
         s_nxt.bytecnt = 2'h0;
         s_nxt.sda_low = 1'b0;
      end else if (stop_c) begin
         s_nxt.st = PRX_ST_IDLE;
         s_nxt.sda_low = 1'b0;
      end else begin
         case (s_r.st)
            PRX_ST_IDLE: begin
               s_nxt.sda_low = 1'b0;
            end
            PRX_ST_RX: begin
               if (scl_rise) begin
                  s_nxt.shreg = {s_r.shreg[6:0], sda_in};
                  s_nxt.bitcnt = s_r.bitcnt + 4'h1;
               end
               if (scl_fall && s_r.bitcnt == 4'h8) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.bytecnt == 2'h0) begin
                     // Address byte: only our address is acknowledged
                     if (s_r.shreg[7:1] == PRX_TARGET_ADDR) begin
                        s_nxt.rd = s_r.shreg[0];
                        s_nxt.sda_low = 1'b1;
                        s_nxt.st = PRX_ST_ACK;
                        s_nxt.txword = rd_word;
                     end else begin
                        s_nxt.st = PRX_ST_WAIT;
                     end
                  end else begin
                     // Command, then low, then high byte
                     s_nxt.sda_low = 1'b1;
                     s_nxt.st = PRX_ST_ACK;
                     case (s_r.bytecnt)
                        2'h1: s_nxt.cmd = s_r.shreg;
                        2'h2: s_nxt.wlow = s_r.shreg;
                        default: begin
                           // Writes land only on the high byte, as a pair
                           case (s_r.cmd)
                              PRX_CMD_ENABLE_INIT,
                              PRX_CMD_PERIOD_INT,
                              PRX_CMD_FORCE_EMIT,
                              PRX_CMD_LOW_THRESH,
                              PRX_CMD_HIGH_THRESH,
                              PRX_CMD_CROSSTALK,
                              PRX_CMD_AUTOCAL: begin
                                 s_nxt.regs[{s_r.cmd[3:0] - (s_r.cmd[3:0] > 4'h0 ?
                                    4'h2 : 4'h0), 1'b0} >> 0] = s_r.wlow;
                              end
                              default: begin
                                 // Read-only codes ignore writes
                              end
                           endcase
                        end
                     endcase
                  end
               end
            end
            PRX_ST_ACK: begin
               if (scl_fall) begin
                  s_nxt.sda_low = 1'b0;
                  if (s_r.rd) begin
                     s_nxt.st = PRX_ST_TX;
                     s_nxt.sda_low = ~s_r.txword[7];
                     s_nxt.bitcnt = 4'h1;
                  end else begin
                     s_nxt.st = PRX_ST_RX;
                     s_nxt.bytecnt = s_r.bytecnt == 2'h3 ? 2'h3 : s_r.bytecnt + 2'h1;
                  end
               end
            end
            PRX_ST_TX: begin
               if (scl_fall) begin
                  if (s_r.bitcnt == 4'h8) begin
                     s_nxt.sda_low = 1'b0;
                     s_nxt.st = PRX_ST_TXACK;
                  end else begin
                     s_nxt.sda_low = ~s_r.txword[4'h7 - s_r.bitcnt];
                     s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                  end
               end
            end
            PRX_ST_TXACK: begin
               if (scl_rise) begin
                  if (sda_in) begin
                     s_nxt.st = PRX_ST_WAIT;
                  end else begin
                     s_nxt.txword = {8'h00, s_r.txword[15:8]};
                     // Acknowledge of the low byte of the flag code clears it
                     if (s_r.cmd == PRX_CMD_FLAGS && s_r.bytecnt == 2'h0) begin
                        s_nxt.flags = 8'h00;
                        s_nxt.irq = 1'b0;
                     end
                     s_nxt.bytecnt = 2'h1;
                     s_nxt.st = PRX_ST_ACK;
                  end
               end
            end
            PRX_ST_WAIT: begin
               s_nxt.sda_low = 1'b0;
            end
            default: s_nxt.st = PRX_ST_IDLE;
         endcase
      end
      // Byte 2 of a write is the low byte; stored with its high byte
      if (s_r.st == PRX_ST_RX && scl_fall && s_r.bitcnt == 4'h8 &&
          s_r.bytecnt == 2'h3) begin
         case (s_r.cmd)
            PRX_CMD_ENABLE_INIT: s_nxt.regs[1] = s_r.shreg;
            PRX_CMD_PERIOD_INT: s_nxt.regs[3] = s_r.shreg;
            PRX_CMD_FORCE_EMIT: s_nxt.regs[5] = s_r.shreg;
            PRX_CMD_LOW_THRESH: s_nxt.regs[7] = s_r.shreg;
            PRX_CMD_HIGH_THRESH: s_nxt.regs[9] = s_r.shreg;
            PRX_CMD_CROSSTALK: s_nxt.regs[11] = s_r.shreg;
            PRX_CMD_AUTOCAL: s_nxt.regs[13] = s_r.shreg;
            default: begin
            end
         endcase
      end

      // ===================== threshold logic ====================
      if (sample_valid_in && !s_r.regs[2][PRX_STOP_BIT]) begin
         s_nxt.result = comp;
         hi_now = comp > high_th;
         lo_now = comp < low_th;
         // Armed state lapses once the result sits between the thresholds
         if (!hi_now && !lo_now) begin
            s_nxt.armed = 1'b0;
         end
         // Fast persistence: once an event has fired one sample retriggers
         if (s_r.regs[2][PRX_FAST_BIT] && s_r.armed) begin
            need = 3'h1;
         end else begin
            need = pers;
         end
         s_nxt.pcnt_hi = hi_now ? (s_r.pcnt_hi < PRX_PERS_MAX ? s_r.pcnt_hi + 3'h1 :
            PRX_PERS_MAX) : 3'h0;
         s_nxt.pcnt_lo = lo_now ? (s_r.pcnt_lo < PRX_PERS_MAX ? s_r.pcnt_lo + 3'h1 :
            PRX_PERS_MAX) : 3'h0;
         case (mode)
            PRX_MODE_OFF: begin
            end
            PRX_MODE_LEVEL: begin
               // Level mode: pin follows near/far state
               if (s_nxt.pcnt_hi >= need) begin
                  s_nxt.close = 1'b1;
               end else if (s_nxt.pcnt_lo >= need) begin
                  s_nxt.close = 1'b0;
               end
               s_nxt.irq = s_nxt.close;
            end
            PRX_MODE_FIRST_HIGH: begin
               if (s_nxt.pcnt_hi >= need) begin
                  s_nxt.flags[PRX_FLAG_CLOSE] = 1'b1;
                  s_nxt.irq = 1'b1;
                  s_nxt.armed = s_r.regs[2][PRX_FAST_BIT];
               end
            end
            PRX_MODE_ON: begin
               // Set wins over a clear in the same cycle
               if (s_nxt.pcnt_hi >= need) begin
                  s_nxt.flags[PRX_FLAG_CLOSE] = 1'b1;
                  s_nxt.irq = 1'b1;
                  s_nxt.armed = s_r.regs[2][PRX_FAST_BIT];
               end
               if (s_nxt.pcnt_lo >= need) begin
                  s_nxt.flags[PRX_FLAG_AWAY] = 1'b1;
                  s_nxt.irq = 1'b1;
                  s_nxt.armed = s_r.regs[2][PRX_FAST_BIT];
               end
            end
            default: begin
            end
         endcase
      end
      if (mode == PRX_MODE_OFF) begin
         s_nxt.irq = 1'b0;
      end
   end

   // State register; low bytes of codes 0x00 and 0x03 reset to 0x01
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_r <= '0;
         s_r.st <= PRX_ST_IDLE;
         s_r.scl_d <= 1'b1;
         s_r.sda_d <= 1'b1;
         s_r.regs[0] <= PRX_RST_CONF_LOW;
         s_r.regs[2] <= PRX_RST_CONF_LOW;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs; pins only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe_n_out = ~s_r.sda_low;
   assign int_n_out = 1'b0;
   assign int_oe_n_out = ~s_r.irq;
   assign measure_run_out = ~s_r.regs[2][PRX_STOP_BIT];
   assign force_mode_out = s_r.regs[4];
   assign emitter_current_out = s_r.regs[5];
   assign autocal_cfg_out = s_r.regs[12];
   assign low_power_cfg_out = s_r.regs[13];

   // ==========================================================
   // Checks
   AST_STOP_RESET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (sample_valid_in && measure_run_out) |=> s_r.result == $past(comp))
      else $error("result not taken while running");
   AST_INT_PIN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $rose(int_oe_n_out) |-> ($past(s_r.st) == PRX_ST_TXACK ||
      ($past(mode) != PRX_MODE_ON && $past(mode) != PRX_MODE_FIRST_HIGH)))
      else $error("interrupt released before flag read");
   AST_STOP_HOLDS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (sample_valid_in && s_r.regs[2][PRX_STOP_BIT]) |=> $stable(s_r.result))
      else $error("result updated while stopped");
   AST_RO_WRITE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_r.st == PRX_ST_RX && scl_fall && s_r.bitcnt == 4'h8 && s_r.bytecnt == 2'h3 &&
       s_r.cmd[7:4] == 4'hf) |=> $stable(s_r.regs))
      else $error("write landed on a read-only code");
   AST_MODE_OFF: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (mode == PRX_MODE_OFF) |=> !s_r.irq || $past(mode) != PRX_MODE_OFF)
      else $error("interrupt asserted while disabled");
   AST_HIGH_EVENT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (sample_valid_in && !s_r.regs[2][0] && mode == PRX_MODE_ON && comp > high_th &&
       pers == 3'h1) |=> s_r.flags[PRX_FLAG_CLOSE])
      else $error("high threshold event missed");
   AST_PERSIST: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $rose(s_r.flags[PRX_FLAG_CLOSE]) |-> (s_r.pcnt_hi >= pers || s_r.regs[2][PRX_FAST_BIT]))
      else $error("event before persistence");
   AST_NACK_OTHER: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (s_r.st == PRX_ST_WAIT) |-> sda_oe_n_out)
      else $error("drove bus for another address");
endmodule
`default_nettype wire

//--- verification/prxreg_host.sv
// Host controller model: drives SCL and SDA for word transfers.
// Assumes a 40 MHz bench clock; SDA has a pull-up, SCL is host-only.
`default_nettype none
module prxreg_host (
   // Clock
   input wire logic clk_in,
   // Device SDA drive
   input wire logic sda_out_in,
   input wire logic sda_oe_n_in,
   // Bus lines
   output logic scl_out,
   output logic sda_line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sda_drv_r = 1'b1;
   initial scl_out = 1'b1;
   // ==========================================================
   // Wired-AND with pull-up: a released line reads high, never stale
   assign sda_line_out = sda_drv_r & (sda_oe_n_in | sda_out_in);
   // ==========================================================
   // Line sequencing
   // Pins move just after an edge, then hold for n clocks
   task automatic step(input logic s, input logic d, input int n);
      scl_out <= s;
      sda_drv_r <= d;
      repeat (n) @(posedge clk_in);
   endtask
   // SDA moves only while SCL is low, so data never looks like a start or stop
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, b, 4);
      step(1'b1, b, 4);
      r = sda_line_out;
      step(1'b0, b, 1);
   endtask
   // Start and repeated start share one shape
   task automatic start_cond();
      step(1'b0, 1'b1, 4);
      step(1'b1, 1'b1, 4);
      step(1'b1, 1'b0, 4);
      step(1'b0, 1'b0, 1);
   endtask
   task automatic stop_cond();
      step(1'b0, 1'b0, 4);
      step(1'b1, 1'b0, 4);
      step(1'b1, 1'b1, 4);
   endtask
   // ==========================================================
   // Byte and word transfers, most significant bit first
   task automatic send_byte(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ok = ok & ~r;
   endtask
   // The last read byte gets no acknowledge so the target lets go
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
   // Command code first, then low byte, then high byte
   task automatic xfer(input logic is_read, input logic [6:0] addr,
                       input logic [7:0] cmd, inout logic [15:0] data, output logic ok);
      ok = 1'b1;
      start_cond();
      send_byte({addr, 1'b0}, ok);
      send_byte(cmd, ok);
      if (is_read) begin
         start_cond();
         send_byte({addr, 1'b1}, ok);
         recv_byte(1'b0, data[7:0]);
         recv_byte(1'b1, data[15:8]);
      end else begin
         send_byte(data[7:0], ok);
         send_byte(data[15:8], ok);
      end
      stop_cond();
   endtask
endmodule
`default_nettype wire

//--- verification/prxreg_top_test.sv
// Bench for the proximity register bank, I2C target and event logic.
// Assumes prxreg_pkg, prxreg_top and the host model prxreg_host.
`default_nettype none
module prxreg_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import prxreg_pkg::*;
   // ==========================================================
   // Clock, reset and wiring
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic scl;
   logic sda;
   logic sda_out;
   logic sda_oe_n;
   logic sample_valid = 1'b0;
   logic [PRX_RESULT_W-1:0] raw_result = 12'h000;
   logic [15:0] autocal_result = 16'h0abc;
   logic measure_run;
   logic [7:0] force_mode;
   logic [7:0] emitter_current;
   logic [7:0] autocal_cfg;
   logic [7:0] low_power_cfg;
   logic int_n;
   logic int_oe_n;
   logic ok;
   logic [15:0] word;
   int num_errors = 0;
   int checks = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   prxreg_top dut (
      .clk_in(clk), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n_out(sda_oe_n), .sample_valid_in(sample_valid),
      .raw_result_in(raw_result), .autocal_result_in(autocal_result),
      .measure_run_out(measure_run), .force_mode_out(force_mode),
      .emitter_current_out(emitter_current), .autocal_cfg_out(autocal_cfg),
      .low_power_cfg_out(low_power_cfg), .int_n_out(int_n), .int_oe_n_out(int_oe_n)
   );
   prxreg_host host (
      .clk_in(clk), .sda_out_in(sda_out), .sda_oe_n_in(sda_oe_n), .scl_out(scl),
      .sda_line_out(sda)
   );
   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // High on int_oe_n means the interrupt pin is released
   task automatic chk_int(input logic exp);
      check("interrupt released", {15'h0, exp}, {15'h0, int_oe_n});
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
      word = data;
      host.xfer(1'b0, PRX_TARGET_ADDR, cmd, word, ok);
      check("write acknowledge", 16'h0001, {15'h0, ok});
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [15:0] exp, input string name);
      host.xfer(1'b1, PRX_TARGET_ADDR, cmd, word, ok);
      check("read acknowledge", 16'h0001, {15'h0, ok});
      check(name, exp, word);
   endtask
   // One-clock strobe per sample; events land on the next clock
   task automatic sample(input logic [11:0] v, input int n);
      repeat (n) begin
         sample_valid <= 1'b1;
         raw_result <= v;
         @(posedge clk);
         sample_valid <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset_values();
      chk_int(1'b1);
      check("interrupt level", 16'h0000, {15'h0, int_n});
      check("measure run", 16'h0000, {15'h0, measure_run});
      rd(PRX_CMD_ENABLE_INIT, 16'h0001, "enable init");
      rd(PRX_CMD_PERIOD_INT, 16'h0001, "period cfg");
      for (int c = 4; c <= 8; c++) begin
         rd(8'(c), 16'h0000, "cleared setting");
      end
      rd(PRX_CMD_RESULT, 16'h0000, "result");
      rd(PRX_CMD_FLAGS, 16'h0000, "event flags");
      rd(PRX_CMD_IDENT, PRX_IDENT_VALUE, "identity");
      rd(PRX_CMD_AC_RESULT, 16'h0abc, "autocal result");
      $display("test reset_values done");
   endtask
   // Reserved bytes of 0x00 and 0x03 high are never written
   task automatic test_rw_regs();
      wr(PRX_CMD_FORCE_EMIT, 16'ha55a);
      check("force mode", 16'h005a, {8'h00, force_mode});
      check("emitter current", 16'h00a5, {8'h00, emitter_current});
      rd(PRX_CMD_FORCE_EMIT, 16'ha55a, "force emitter");
      wr(PRX_CMD_AUTOCAL, 16'h3cc3);
      check("autocal cfg", 16'h00c3, {8'h00, autocal_cfg});
      check("low power cfg", 16'h003c, {8'h00, low_power_cfg});
      rd(PRX_CMD_AUTOCAL, 16'h3cc3, "autocal low power");
      wr(PRX_CMD_CROSSTALK, 16'h0321);
      rd(PRX_CMD_CROSSTALK, 16'h0321, "crosstalk level");
      word = 16'hffff;
      host.xfer(1'b0, PRX_TARGET_ADDR, PRX_CMD_RESULT, word, ok);
      rd(PRX_CMD_RESULT, 16'h0000, "read-only result");
      word = 16'h0000;
      host.xfer(1'b0, 7'h61, PRX_CMD_FORCE_EMIT, word, ok);
      check("foreign address ack", 16'h0000, {15'h0, ok});
      rd(PRX_CMD_FORCE_EMIT, 16'ha55a, "foreign write ignored");
      $display("test rw_regs done");
   endtask
   task automatic test_persistence();
      wr(PRX_CMD_CROSSTALK, 16'h0000);
      wr(PRX_CMD_LOW_THRESH, 16'h0100);
      wr(PRX_CMD_HIGH_THRESH, 16'h0200);
      for (int p = 0; p < 4; p++) begin
         wr(PRX_CMD_PERIOD_INT, {10'h000, 2'(p), PRX_MODE_ON, 2'b00});
         sample(12'h300, p);
         chk_int(1'b1);
         sample(12'h300, 1);
         chk_int(1'b0);
         rd(PRX_CMD_RESULT, 16'h0300, "result");
         chk_int(1'b0);
         rd(PRX_CMD_FLAGS, 16'h0200, "close flag");
         chk_int(1'b1);
         sample(12'h050, p);
         chk_int(1'b1);
         sample(12'h050, 1);
         chk_int(1'b0);
         rd(PRX_CMD_FLAGS, 16'h0100, "away flag");
         chk_int(1'b1);
      end
      $display("test persistence done");
   endtask
   task automatic test_modes();
      wr(PRX_CMD_PERIOD_INT, {10'h000, PRX_MODE_OFF, 2'b00});
      sample(12'h300, 2);
      chk_int(1'b1);
      wr(PRX_CMD_PERIOD_INT, {10'h000, PRX_MODE_LEVEL, 2'b00});
      sample(12'h050, 1);
      chk_int(1'b1);
      sample(12'h300, 1);
      chk_int(1'b0);
      sample(12'h050, 1);
      chk_int(1'b1);
      host.xfer(1'b1, PRX_TARGET_ADDR, PRX_CMD_FLAGS, word, ok);
      wr(PRX_CMD_PERIOD_INT, {10'h000, PRX_MODE_FIRST_HIGH, 2'b00});
      sample(12'h300, 1);
      chk_int(1'b0);
      rd(PRX_CMD_FLAGS, 16'h0200, "first high flag");
      chk_int(1'b1);
      $display("test modes done");
   endtask
   // Count of four with fast persistence: only the first event waits
   task automatic test_fast_cancel_stop();
      wr(PRX_CMD_PERIOD_INT, 16'h003e);
      check("measure run", 16'h0001, {15'h0, measure_run});
      sample(12'h050, 3);
      chk_int(1'b1);
      sample(12'h050, 1);
      rd(PRX_CMD_FLAGS, 16'h0100, "first away flag");
      sample(12'h300, 1);
      chk_int(1'b0);
      rd(PRX_CMD_FLAGS, 16'h0200, "close flag");
      sample(12'h050, 1);
      chk_int(1'b0);
      rd(PRX_CMD_FLAGS, 16'h0100, "away flag");
      wr(PRX_CMD_CROSSTALK, 16'h0100);
      sample(12'h350, 1);
      rd(PRX_CMD_RESULT, 16'h0250, "cancelled result");
      sample(12'h050, 1);
      rd(PRX_CMD_RESULT, 16'h0000, "saturated result");
      wr(PRX_CMD_PERIOD_INT, 16'h0001);
      check("measure run", 16'h0000, {15'h0, measure_run});
      sample(12'h7ff, 1);
      rd(PRX_CMD_RESULT, 16'h0000, "stopped result");
      $display("test fast_cancel_stop done");
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
      test_reset_values();
      test_rw_regs();
      test_persistence();
      test_modes();
      test_fast_cancel_stop();
      complete_run();
   end
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      $display("mismatch run length expected finish seen timeout");
      complete_run();
   end
endmodule
`default_nettype wire
